// file: wdtc_defines.vh
/*
 Constants of the watchdog timer control block: register field positions,
 reset values, prescale codes and clock figures.
 Assumes inclusion by bare name from the design files.
*/
`ifndef WDTC_DEFINES_VH
`define WDTC_DEFINES_VH

// Control register field positions
`define WDTC_BIT_UNLOCK 0
`define WDTC_BIT_ENABLE 1
`define WDTC_BIT_STATUS 2
`define WDTC_BIT_IRQSEL 3
`define WDTC_PRE_LSB 4
`define WDTC_PRE_MSB 7

// Reset values of the fields
`define WDTC_RST_PRE 4'h7
`define WDTC_RST_IRQSEL 1'b0
`define WDTC_RST_ENABLE 1'b1
`define WDTC_RST_STATUS 1'b0

// Prescale codes
`define WDTC_PRE_MAX_VALID 4'h7
`define WDTC_PRE_AUTO_RST 4'h8
`define WDTC_PRE_DL_RST 4'h9

// Counter layout: timeout after 2^pre x 2^9 ticks
`define WDTC_BASE_SHIFT 9
`define WDTC_CNT_WIDTH 16

// Clock figures: system clock 100 MHz; tick clock 32.768 kHz
`define WDTC_SYS_HZ 100000000
`define WDTC_TICK_HZ 32768

`endif

// file: wdtc_tick_gen.v
/*
 Fractional divider that makes one-cycle ticks at the watchdog input rate
 from the system clock.
 Assumes a single system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdtc_defines.vh"

module wdtc_tick_gen #(
    parameter integer SYS_HZ = `WDTC_SYS_HZ,
    parameter integer TICK_HZ = `WDTC_TICK_HZ
) (
    // Clock and reset
    input wire i_clock,
    input wire i_srst,
    // Tick out
    output reg o_tick
);

    // Rates as 32-bit words so the sums below keep exact widths
    localparam [31:0] TICK_STEP = TICK_HZ;
    localparam [31:0] SYS_STEP = SYS_HZ;

    reg [31:0] acc_ff;
    wire [32:0] acc_sum = {1'b0, acc_ff} + {1'b0, TICK_STEP};

    // Accumulator keeps the average rate exact, no drift from rounding
    always @(posedge i_clock) begin
        if (i_srst) begin
            acc_ff <= 32'h0;
            o_tick <= 1'b0;
        end else if (acc_sum >= {1'b0, SYS_STEP}) begin
            acc_ff <= acc_sum[31:0] - SYS_STEP;
            o_tick <= 1'b1;
        end else begin
            acc_ff <= acc_sum[31:0];
            o_tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: wdtc_core.v
/*
 Watchdog timer control: control register, unlock sequence, timeout
 counter, status flag and reset or interrupt response.
 Assumes the core presents one instruction strobe per instruction, a
 register write strobe with data, and synchronous event inputs.
*/
// Overview of operation
// - Timeout at end of selected period sets the status flag.
// - Status flag clears only by software zero write or pin reset.
// - Watchdog-caused system reset leaves the status flag set.
// - Setting run enable starts watchdog and zeroes its counter.
// - Each further enable-setting write while running restarts the period.
// - Unserviced timeout gives system reset or interrupt, per select bit.
// - Zero write, watchdog reset, supply or lock event stop it; pin reset restarts it with enable set.
// - Control writes only take effect right after the unlock instruction.
// - Prescale 0-7 gives 2^code x 2^9 ticks; 8, 9 reset; rest invalid.
// - Select clear means system reset; set means interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "wdtc_defines.vh"

module wdtc_core #(
    parameter integer CNT_WIDTH = `WDTC_CNT_WIDTH,
    parameter integer SYS_HZ = `WDTC_SYS_HZ,
    parameter integer TICK_HZ = `WDTC_TICK_HZ
) (
    // Clock and resets
    input wire i_clock,
    input wire i_srst,
    input wire i_pin_reset,
    // Instruction and register access
    input wire i_instr_strobe,
    input wire i_ctrl_write,
    input wire [7:0] i_ctrl_wdata,
    input wire i_unlock_set,
    // System events
    input wire i_supply_monitor_event,
    input wire i_lock_event,
    // Outputs
    output reg [7:0] o_watchdog_control,
    output reg o_system_reset,
    output reg o_timeout_irq,
    output reg o_download_reset
);

    // Run states; FIRE is a one-cycle decision and is never held
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_FIRE = 2'h2;

    // Control fields, counter and synchroniser
    reg [3:0] pre_ff;
    reg irqsel_ff;
    reg enable_ff;
    reg status_ff;
    reg unlock_ff;
    reg [1:0] state_ff;
    reg [CNT_WIDTH-1:0] cnt_ff;
    reg [1:0] pin_sync_ff;
    // Next values and fire decisions
    reg [3:0] nxt_pre;
    reg nxt_irqsel;
    reg nxt_enable;
    reg nxt_status;
    reg nxt_unlock;
    reg [1:0] nxt_state;
    reg [1:0] state_land;
    reg [CNT_WIDTH-1:0] nxt_cnt;
    reg fire_rst;
    reg fire_irq;
    reg fire_dl;
    wire tick;
    wire wr_ok;
    wire expired;
    wire pin_rst;

    // Limit bit of counter for a prescale code
    function [CNT_WIDTH-1:0] wdtc_limit;
        input [3:0] code;
        begin
            wdtc_limit = {{(CNT_WIDTH-1){1'b0}}, 1'b1} << (code[2:0] + `WDTC_BASE_SHIFT);
        end
    endfunction

    // Tick phase is free-running, so the first tick after a restart may come
    // early: a period can end up to one tick short, never long
    wdtc_tick_gen #(
        .SYS_HZ(SYS_HZ),
        .TICK_HZ(TICK_HZ)
    ) u_tick (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .o_tick(tick)
    );

    // Reset pin comes from outside, two stages before use
    always @(posedge i_clock) begin
        if (i_srst) begin
            pin_sync_ff <= 2'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[0], i_pin_reset};
        end
    end
    assign pin_rst = pin_sync_ff[1];

    // Write accepted only on the strobed instruction right after unlock;
    // a write level without strobe is ignored
    assign wr_ok = i_instr_strobe && i_ctrl_write && unlock_ff;
    // Counter hit the limit of the selected period; codes above 7 never
    // expire, the counter just wraps
    assign expired = (state_ff == ST_RUN) && (pre_ff <= `WDTC_PRE_MAX_VALID) &&
                     (cnt_ff == wdtc_limit(pre_ff) - {{(CNT_WIDTH-1){1'b0}}, 1'b1}) && tick;

    // Next-state of control fields, counter and state
    always @* begin
        nxt_pre = pre_ff;
        nxt_irqsel = irqsel_ff;
        nxt_enable = enable_ff;
        nxt_status = status_ff;
        nxt_unlock = unlock_ff;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        fire_rst = 1'b0;
        fire_irq = 1'b0;
        fire_dl = 1'b0;
        // Unlock survives exactly one instruction
        if (i_instr_strobe) begin
            nxt_unlock = i_unlock_set && !i_ctrl_write;
        end
        if (state_ff == ST_RUN && tick) begin
            nxt_cnt = cnt_ff + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
        if (wr_ok) begin
            nxt_pre = i_ctrl_wdata[`WDTC_PRE_MSB:`WDTC_PRE_LSB];
            nxt_irqsel = i_ctrl_wdata[`WDTC_BIT_IRQSEL];
            nxt_enable = i_ctrl_wdata[`WDTC_BIT_ENABLE];
            if (!i_ctrl_wdata[`WDTC_BIT_STATUS]) begin
                nxt_status = 1'b0;
            end
            if (i_ctrl_wdata[`WDTC_BIT_ENABLE]) begin
                nxt_cnt = {CNT_WIDTH{1'b0}};
                nxt_state = ST_RUN;
            end else begin
                nxt_state = ST_IDLE;
            end
            // Codes 8 and 9 reset at once; 10-15 do nothing
            if (i_ctrl_wdata[`WDTC_PRE_MSB:`WDTC_PRE_LSB] == `WDTC_PRE_AUTO_RST) begin
                fire_rst = 1'b1;
            end else if (i_ctrl_wdata[`WDTC_PRE_MSB:`WDTC_PRE_LSB] == `WDTC_PRE_DL_RST) begin
                fire_dl = 1'b1;
            end
        end else if (expired) begin
            nxt_status = 1'b1;
            nxt_state = ST_FIRE;
            if (irqsel_ff) begin
                fire_irq = 1'b1;
                nxt_cnt = {CNT_WIDTH{1'b0}};
                nxt_state = ST_RUN;
            end else begin
                fire_rst = 1'b1;
                nxt_enable = 1'b0;
                nxt_state = ST_IDLE;
            end
        end
        // Supply or lock event stops the watchdog; timeout flag stays
        if (i_supply_monitor_event || i_lock_event) begin
            nxt_enable = 1'b0;
            nxt_state = ST_IDLE;
        end
        // Set beats clear: a timeout in the clearing cycle still lands
        if (expired) begin
            nxt_status = 1'b1;
        end
    end

    // Fire is decided within the cycle, so the state register never holds it
    always @* begin
        case (nxt_state)
            ST_IDLE: state_land = ST_IDLE;
            ST_RUN: state_land = ST_RUN;
            ST_FIRE: state_land = ST_IDLE;
            default: state_land = ST_IDLE;
        endcase
    end

    // Core registers; pin reset restores all, watchdog reset keeps status
    always @(posedge i_clock) begin
        if (i_srst || pin_rst) begin
            pre_ff <= `WDTC_RST_PRE;
            irqsel_ff <= `WDTC_RST_IRQSEL;
            enable_ff <= `WDTC_RST_ENABLE;
            status_ff <= `WDTC_RST_STATUS;
            unlock_ff <= 1'b0;
            state_ff <= ST_RUN; // enable resets high, so it runs from reset
            cnt_ff <= {CNT_WIDTH{1'b0}};
            o_system_reset <= 1'b0;
            o_timeout_irq <= 1'b0;
            o_download_reset <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            irqsel_ff <= nxt_irqsel;
            enable_ff <= nxt_enable;
            status_ff <= nxt_status;
            unlock_ff <= nxt_unlock;
            state_ff <= state_land;
            cnt_ff <= nxt_cnt;
            o_system_reset <= fire_rst;
            o_timeout_irq <= fire_irq;
            o_download_reset <= fire_dl;
        end
    end

    // Readback mirrors the next register image so it lines up with state
    // Costs a second copy of the fields but keeps the output a plain flop
    always @(posedge i_clock) begin
        if (i_srst || pin_rst) begin
            o_watchdog_control <= {`WDTC_RST_PRE, `WDTC_RST_IRQSEL, `WDTC_RST_STATUS,
                                   `WDTC_RST_ENABLE, 1'b0};
        end else begin
            o_watchdog_control <= {nxt_pre, nxt_irqsel, nxt_status, nxt_enable, nxt_unlock};
        end
    end

endmodule
`default_nettype wire

// file: wdtc_core_props.sv
/*
 Checker for the watchdog control core.
 Assumes binding to wdtc_core on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wdtc_props (
    // Clock and resets
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_pin_reset,
    // Access
    input wire logic i_instr_strobe,
    input wire logic i_ctrl_write,
    input wire logic [7:0] i_ctrl_wdata,
    input wire logic i_unlock_set,
    // Events
    input wire logic i_supply_monitor_event,
    input wire logic i_lock_event,
    // Outputs
    input wire logic [7:0] o_watchdog_control,
    input wire logic o_system_reset,
    input wire logic o_timeout_irq,
    input wire logic o_download_reset
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    wire [7:0] c = o_watchdog_control;
    wire wr = i_instr_strobe && i_ctrl_write;
    wire ok = wr && c[0];
    // Pin reset reaches the core late, through a synchroniser
    reg [3:0] pin_q = 4'h0;
    reg [1:0] wr_q = 2'h0;
    always @(posedge i_clock) begin
        pin_q <= {pin_q[2:0], i_pin_reset || i_srst};
        wr_q <= {wr_q[0], wr};
    end
    a_irq_one_cycle: assert property (o_timeout_irq |=> !o_timeout_irq)
        else $error("interrupt pulse too long");
    a_irq_sets_status: assert property (o_timeout_irq |-> c[2] && c[3])
        else $error("interrupt without status or select");
    a_status_sticky: assert property ($fell(c[2]) |-> (|wr_q) || (|pin_q))
        else $error("status cleared without cause");
    a_unlock_arms: assert property (i_instr_strobe && i_unlock_set && !i_ctrl_write |=> c[0])
        else $error("unlock not set");
    a_unlock_once: assert property (c[0] && i_instr_strobe && !i_unlock_set |=> !c[0])
        else $error("unlock outlived one instruction");
    a_locked_ignored: assert property (wr && !c[0] && !(|pin_q) |=> $stable(c[7:3]))
        else $error("locked write took effect");
    a_write_takes: assert property (ok && !i_ctrl_wdata[7] |=> c[7:3] == $past(i_ctrl_wdata[7:3]))
        else $error("unlocked write lost");
    a_zero_stops: assert property (ok && !i_ctrl_wdata[1] |=> !c[1])
        else $error("enable not cleared");
    a_event_stops: assert property (i_supply_monitor_event || i_lock_event |=> !c[1])
        else $error("event did not stop watchdog");
    a_dl_pulse: assert property (ok && i_ctrl_wdata[7:4] == 4'h9 |-> ##[1:2] o_download_reset)
        else $error("download reset missing");
endmodule
bind wdtc_core wdtc_props i_wdtc_props (.i_clock(i_clock), .i_srst(i_srst),
    .i_pin_reset(i_pin_reset), .i_instr_strobe(i_instr_strobe), .i_ctrl_write(i_ctrl_write),
    .i_ctrl_wdata(i_ctrl_wdata), .i_unlock_set(i_unlock_set),
    .i_supply_monitor_event(i_supply_monitor_event), .i_lock_event(i_lock_event),
    .o_watchdog_control(o_watchdog_control), .o_system_reset(o_system_reset),
    .o_timeout_irq(o_timeout_irq), .o_download_reset(o_download_reset));
`default_nettype wire

// file: tb.sv
/*
 Self-checking bench for wdtc_core.
 Assumes a tick every four system cycles via TICK_HZ.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, srst = 1'b1, pin = 1'b0, stb = 1'b0, wr = 1'b0, unl = 1'b0;
    logic supply_monitor_event = 1'b0, lck = 1'b0;
    logic [7:0] wd = 8'h00;
    wire [7:0] ctl;
    wire sys_rst, irq, dl_rst;
    int errors = 0, n_tests = 0, cyc = 0, n;
    wdtc_core #(.TICK_HZ(25000000)) i_wdtc_core (.i_clock(clk), .i_srst(srst),
        .i_pin_reset(pin), .i_instr_strobe(stb), .i_ctrl_write(wr), .i_ctrl_wdata(wd),
        .i_unlock_set(unl), .i_supply_monitor_event(supply_monitor_event), .i_lock_event(lck),
        .o_watchdog_control(ctl), .o_system_reset(sys_rst), .o_timeout_irq(irq),
        .o_download_reset(dl_rst));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well above the roughly 15000 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One strobed instruction, driven at the falling edge
    task automatic ins(input logic u, input logic w, input logic [7:0] d);
        @(negedge clk);
        stb = 1'b1;
        unl = u;
        wr = w;
        wd = d;
        @(negedge clk);
        stb = 1'b0;
        unl = 1'b0;
        wr = 1'b0;
    endtask
    task automatic wrc(input logic [7:0] d);
        ins(1'b1, 1'b0, 8'h00);
        ins(1'b0, 1'b1, d);
    endtask
    // Cycles until a pulse: 0 interrupt, 1 reset, 2 download
    task automatic wt(input int s, output int k);
        k = 0;
        while (!((s == 0) ? irq === 1'b1 : (s == 1) ? sys_rst === 1'b1 : dl_rst === 1'b1)
               && k < 5000) begin
            @(negedge clk);
            k++;
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        chk("ctrl reset", 8'h72, ctl);
        ins(1'b0, 1'b1, 8'h00);
        chk("locked write", 8'h72, ctl);
        ins(1'b1, 1'b0, 8'h00);
        chk("unlock bit", 8'h73, ctl);
        ins(1'b0, 1'b0, 8'h00);
        chk("unlock cancel", 8'h72, ctl);
        ins(1'b0, 1'b1, 8'h00);
        chk("late write", 8'h72, ctl);
        wrc(8'h0a);
        chk("irq mode", 8'h0a, ctl);
        repeat (1500) @(negedge clk);
        wrc(8'h0a);
        wt(0, n);
        chk("period", 8'h01, 8'(n > 2030 && n < 2060));
        chk("status set", 8'h0e, ctl);
        wrc(8'h0a);
        chk("status clear", 8'h0a, ctl);
        wrc(8'h02);
        wt(1, n);
        @(negedge clk);
        chk("reset fired", 8'h01, 8'(n > 2030 && n < 2060));
        chk("status kept", 8'h04, ctl);
        pin = 1'b1;
        repeat (3) @(negedge clk);
        pin = 1'b0;
        repeat (4) @(negedge clk);
        chk("pin reset", 8'h72, ctl);
        wrc(8'h02);
        supply_monitor_event = 1'b1;
        @(negedge clk);
        supply_monitor_event = 1'b0;
        chk("supply stop", 8'h00, ctl);
        wrc(8'h02);
        lck = 1'b1;
        @(negedge clk);
        lck = 1'b0;
        chk("lock stop", 8'h00, ctl);
        wrc(8'h92);
        wt(2, n);
        chk("download", 8'h01, 8'(n < 4));
        wrc(8'h82);
        wt(1, n);
        chk("auto reset", 8'h01, 8'(n < 4));
        wrc(8'h1a);
        wt(0, n);
        chk("period code 1", 8'h01, 8'(n > 4080 && n < 4110));
        chk("status code 1", 8'h1e, ctl);
        wrc(8'ha2);
        wt(1, n);
        chk("invalid quiet", 8'h01, 8'(n >= 5000));
        chk("invalid ctrl", 8'ha2, ctl);
        wrap_up();
    end
endmodule
`default_nettype wire
